//--- verilog/tsc_pkg.sv
// constants, field layout and state encoding of the transceiver state controller
package tsc_pkg;

   // register index on the plain register port
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_CAL1   = 8'h01;
   localparam logic [7:0] REG_CAL2   = 8'h02;
   localparam logic [7:0] REG_STATUS = 8'h03;

   // mode control fields
   localparam int MODE_W         = 10;
   localparam int MODE_SOFT_REG_RESET_BIT  = 0;
   localparam int MODE_SYN_BIT   = 2;
   localparam int MODE_TRC_BIT   = 3;
   localparam int MODE_DR_LSB    = 4;
   localparam int MODE_EXBR_BIT  = 7;
   localparam int MODE_DATA_RATE_CLOCK_ENABLE_BIT  = 8;
   localparam int MODE_IF_CLOCK_ENABLE_BIT  = 9;
   localparam logic [9:0] MODE_RESET = 10'h083;
   localparam logic [1:0] DR_3M      = 2'h3;

   // calibration control I and II fields
   localparam int CAL1_TEMP_GO_BIT = 0;
   localparam int CAL1_RSSI_MAN_BIT = 2;
   localparam int CAL1_SEL_LSB     = 4;
   localparam int CAL_STEPS        = 5;
   localparam int CAL2_CAL_GO_BIT  = 1;
   localparam int CAL2_RSSI_GO_BIT = 2;

   // step index 5 means all selected steps are done, ending time runs
   localparam logic [2:0] CAL_END = 3'h5;

   // timing: clock period and bit period, counts derived from them
   localparam int CLK_PERIOD_PS = 5000;
   localparam int BIT_1M_PS     = 1000000;
   localparam int BIT_CYCLES_1M = BIT_1M_PS / CLK_PERIOD_PS;
   localparam int RATE_3M_STEP  = 3;
   localparam logic [6:0] RX_SYNC_BITS = 7'h48;
   localparam logic [6:0] END_CAL_BITS = 7'h0c;

   typedef enum logic [6:0] {
      ST_SLEEP = 7'h01,
      ST_STANDBY_STATE  = 7'h02,
      ST_PLL   = 7'h04,
      ST_RX    = 7'h08,
      ST_TX    = 7'h10,
      ST_RSSI  = 7'h20,
      ST_CAL   = 7'h40
   } tsc_state_t;

endpackage : tsc_pkg

//--- verilog/tsc_bit_tick.sv
// bit period tick generator for the 1 Mbps and 3 Mbps modes
`timescale 1ns/1ps
`default_nettype none
module tsc_bit_tick import tsc_pkg::*; #(
   parameter int unsigned CYCLES_PER_US = BIT_CYCLES_1M
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // rate select and tick
   input  wire logic rate_3m,
   output logic      bit_tick
);

   localparam int AW = $clog2(CYCLES_PER_US + RATE_3M_STEP + 1);
   localparam logic [AW-1:0] MODULUS = AW'(CYCLES_PER_US);

   if (CYCLES_PER_US < RATE_3M_STEP) begin : g_chk
      $error("tsc_bit_tick: bit period shorter than three clocks");
   end

   logic [AW-1:0] acc_reg;
   logic [AW-1:0] acc_sum;

   // fractional accumulator keeps the 3 Mbps period exact on average
   assign acc_sum = acc_reg + (rate_3m ? AW'(RATE_3M_STEP) : AW'(1));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_reg  <= '0;
         bit_tick <= 1'b0;
      end else if (acc_sum >= MODULUS) begin
         acc_reg  <= acc_sum - MODULUS;
         bit_tick <= 1'b1;
      end else begin
         acc_reg  <= acc_sum;
         bit_tick <= 1'b0;
      end
   end

endmodule : tsc_bit_tick
`default_nettype wire

//--- verilog/tsc_controller.sv
// operating state controller of the transceiver: power states and sequences
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - after reset the block sits in sleep while the standby pin is low
// - sleep keeps crystal and analog power off; no baseband clock
// - standby pin rising moves sleep to standby; crystal on, analog off
// - standby pin low sends every state straight back to sleep
// - host sets data rate clock enable, then temp go starts a measurement
// - finished temperature measurement clears temp go and ends measurement
// - temperature waits for calibration or rssi, and they wait for it
// - synthesizer warm from standby needs synth on, radio low, no cal
// - synthesizer stays powered through the whole radio state
// - radio pin rising in synth warm enters rx or tx by tx/rx select
// - rx powers receiver only, tx powers transmitter only
// - no direct rx/tx swap; radio pin low returns to synth warm
// - rssi in rx with data rate clock; auto from frame events or manual go
// - rssi go outside rx is kept until rssi is next entered from rx, or a reset
// - rssi done returns to rx by itself
// - host enables clocks; calibration go in standby enters calibration
// - calibration go outside standby is kept until the next standby
// - selected calibration steps run in fixed order, unselected skipped
// - normal calibration end clears calibration go and returns to standby
// - host clearing calibration go aborts all steps back to standby
// - rx sync and calibration ending are counted in bit periods
// - bit period is 1 us at 1 Mbps and a third of that at 3 Mbps
// - pins: standby low sleep, standby only standby, both high radio
// - tx/rx select sampled at radio pin rise; refused without synthesizer
// - control bits reset on hardware reset pin low or soft reset write
module tsc_controller import tsc_pkg::*; #(
   parameter int unsigned CYCLES_PER_US = BIT_CYCLES_1M
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // mode and reset pins
   input  wire logic        standby_select_pin,
   input  wire logic        radio_active_pin,
   input  wire logic        hw_reset_pin_n,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // receive events and analog completion
   input  wire logic        rx_frame_pulse,
   input  wire logic        fifo_packet_flag,
   input  wire logic        cal_step_done,
   input  wire logic        temp_done,
   input  wire logic        rssi_done,
   // power and status outputs
   output logic             baseband_clock_out,
   output logic             xtal_on,
   output logic             analog_power_on,
   output logic             synth_power_on,
   output logic             rx_power_on,
   output logic             tx_power_on,
   output logic             rssi_active,
   output logic             temp_active,
   output logic [4:0]       cal_step_active,
   output logic [6:0]       state_code
);

   tsc_state_t state_reg, state_next;
   logic [2:0] pin_meta, pin_sync;
   logic [1:0] pin_prev;
   logic       ms0, ms1, ms0_rise, ms1_rise, hw_rst;
   logic [MODE_W-1:0] mode_reg;
   logic [4:0] cal_sel_reg;
   logic       rssi_man_reg, temp_go_reg, cal_go_reg, rssi_go_reg;
   logic       temp_active_reg;
   logic [2:0] cal_idx_reg, cal_idx_next;
   logic [6:0] end_cnt_reg, rx_sync_cnt_reg;
   logic       bit_tick, reg_reset, wr_mode, wr_cal1, wr_cal2;
   logic       cal_finish, temp_start, temp_finish, rssi_trig, rssi_enter;

   // lowest selected step at or after 'from', or CAL_END when none is left
   function automatic logic [2:0] first_sel(input logic [4:0] sel,
                                            input logic [2:0] from);
      logic [2:0] r;
      r = CAL_END;
      for (int i = CAL_STEPS - 1; i >= 0; i--) begin
         if (sel[i] && (3'(i) >= from)) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : first_sel

   tsc_bit_tick #(
      .CYCLES_PER_US (CYCLES_PER_US)
   ) u_tick (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .rate_3m  (mode_reg[MODE_DR_LSB+:2] == DR_3M),
      .bit_tick (bit_tick)
   );

   // pins pass two flops; edges are taken after the second only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_meta <= 3'h4;
         pin_sync <= 3'h4;
         pin_prev <= 2'h0;
      end else begin
         pin_meta <= {hw_reset_pin_n, radio_active_pin, standby_select_pin};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync[1:0];
      end
   end

   assign ms0      = pin_sync[0];
   assign ms1      = pin_sync[1];
   assign hw_rst   = !pin_sync[2];
   assign ms0_rise = ms0 && !pin_prev[0];
   assign ms1_rise = ms1 && !pin_prev[1];

   assign wr_mode   = reg_wr && (reg_addr == REG_MODE);
   assign wr_cal1   = reg_wr && (reg_addr == REG_CAL1);
   assign wr_cal2   = reg_wr && (reg_addr == REG_CAL2);
   assign reg_reset = hw_rst || (wr_mode && !reg_wdata[MODE_SOFT_REG_RESET_BIT]);

   // soft reset bit reads back as one once its reset has been applied
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_reg     <= MODE_RESET;
         cal_sel_reg  <= 5'h00;
         rssi_man_reg <= 1'b0;
      end else if (reg_reset) begin
         mode_reg     <= MODE_RESET;
         cal_sel_reg  <= 5'h00;
         rssi_man_reg <= 1'b0;
      end else begin
         if (wr_mode) begin
            mode_reg <= reg_wdata[MODE_W-1:0];
         end
         if (wr_cal1) begin
            cal_sel_reg  <= reg_wdata[CAL1_SEL_LSB+:CAL_STEPS];
            rssi_man_reg <= reg_wdata[CAL1_RSSI_MAN_BIT];
         end
      end
   end

   // command bits: a host write in the clearing cycle wins over the clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cal_go_reg  <= 1'b0;
         rssi_go_reg <= 1'b0;
         temp_go_reg <= 1'b0;
      end else if (reg_reset) begin
         cal_go_reg  <= 1'b0;
         rssi_go_reg <= 1'b0;
         temp_go_reg <= 1'b0;
      end else begin
         if (wr_cal2) begin
            cal_go_reg  <= reg_wdata[CAL2_CAL_GO_BIT];
            rssi_go_reg <= reg_wdata[CAL2_RSSI_GO_BIT];
         end else begin
            if (cal_finish) begin
               cal_go_reg <= 1'b0;
            end
            if (rssi_enter) begin
               rssi_go_reg <= 1'b0;
            end
         end
         if (wr_cal1) begin
            temp_go_reg <= reg_wdata[CAL1_TEMP_GO_BIT];
         end else if (temp_finish) begin
            temp_go_reg <= 1'b0;
         end
      end
   end

   // temperature runs beside any awake state except calibration and rssi
   assign temp_start = temp_go_reg && mode_reg[MODE_DATA_RATE_CLOCK_ENABLE_BIT] &&
                       !temp_active_reg && (state_reg != ST_SLEEP) &&
                       (state_reg != ST_CAL) && (state_reg != ST_RSSI);
   assign temp_finish = temp_active_reg && temp_done;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         temp_active_reg <= 1'b0;
      end else if (state_next == ST_SLEEP || temp_finish) begin
         temp_active_reg <= 1'b0;
      end else if (temp_start) begin
         temp_active_reg <= 1'b1;
      end
   end

   assign rssi_trig = mode_reg[MODE_DATA_RATE_CLOCK_ENABLE_BIT] && !temp_active_reg &&
                      !temp_start &&
                      (rssi_man_reg ? rssi_go_reg
                                    : (rx_frame_pulse || fifo_packet_flag));
   assign rssi_enter = (state_reg == ST_RX) && (state_next == ST_RSSI);

   assign cal_finish = (state_reg == ST_CAL) && (cal_idx_reg == CAL_END) &&
                       bit_tick && (end_cnt_reg == END_CAL_BITS - 7'h01);

   always_comb begin
      state_next = state_reg;
      if (!ms0) begin
         state_next = ST_SLEEP;
      end else begin
         case (state_reg)
            ST_SLEEP: begin
               if (ms0_rise) begin
                  state_next = ST_STANDBY_STATE;
               end
            end
            ST_STANDBY_STATE: begin
               if (cal_go_reg && !temp_active_reg && !temp_start) begin
                  state_next = ST_CAL;
               end else if (mode_reg[MODE_SYN_BIT] && !ms1 && !cal_go_reg) begin
                  state_next = ST_PLL;
               end
            end
            ST_PLL: begin
               if (!mode_reg[MODE_SYN_BIT]) begin
                  state_next = ST_STANDBY_STATE;
               end else if (ms1_rise) begin
                  state_next = mode_reg[MODE_TRC_BIT] ? ST_TX : ST_RX;
               end
            end
            ST_RX: begin
               if (!ms1) begin
                  state_next = ST_PLL;
               end else if (rssi_trig) begin
                  state_next = ST_RSSI;
               end
            end
            ST_RSSI: begin
               if (!ms1) begin
                  state_next = ST_PLL;
               end else if (rssi_done) begin
                  state_next = ST_RX;
               end
            end
            ST_TX: begin
               if (!ms1) begin
                  state_next = ST_PLL;
               end
            end
            ST_CAL: begin
               if (!cal_go_reg || cal_finish) begin
                  state_next = ST_STANDBY_STATE;
               end
            end
            default: state_next = ST_SLEEP;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // calibration walks the selection in fixed order; done pulses advance it
   always_comb begin
      cal_idx_next = cal_idx_reg;
      if (state_next != ST_CAL) begin
         cal_idx_next = CAL_END;
      end else if (state_reg != ST_CAL) begin
         cal_idx_next = first_sel(cal_sel_reg, 3'h0);
      end else if (cal_idx_reg != CAL_END && cal_step_done) begin
         cal_idx_next = first_sel(cal_sel_reg, cal_idx_reg + 3'h1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cal_idx_reg <= CAL_END;
         end_cnt_reg <= 7'h00;
      end else begin
         cal_idx_reg <= cal_idx_next;
         if (state_next != ST_CAL || cal_idx_reg != CAL_END) begin
            end_cnt_reg <= 7'h00;
         end else if (bit_tick) begin
            end_cnt_reg <= end_cnt_reg + 7'h01;
         end
      end
   end

   // receive sync time counted in bit periods, saturating
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_sync_cnt_reg <= 7'h00;
      end else if (state_reg != ST_RX && state_reg != ST_RSSI) begin
         rx_sync_cnt_reg <= 7'h00;
      end else if (bit_tick && rx_sync_cnt_reg != RX_SYNC_BITS) begin
         rx_sync_cnt_reg <= rx_sync_cnt_reg + 7'h01;
      end
   end

   // outputs other than temp_active follow the next state so they change with state_reg
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         xtal_on         <= 1'b0;
         analog_power_on <= 1'b0;
         synth_power_on  <= 1'b0;
         rx_power_on     <= 1'b0;
         tx_power_on     <= 1'b0;
         rssi_active     <= 1'b0;
         temp_active     <= 1'b0;
         cal_step_active <= 5'h00;
         state_code      <= ST_SLEEP;
      end else begin
         xtal_on         <= state_next != ST_SLEEP;
         analog_power_on <= !(state_next inside {ST_SLEEP, ST_STANDBY_STATE});
         synth_power_on  <= state_next inside {ST_PLL, ST_RX, ST_TX,
                                               ST_RSSI};
         rx_power_on     <= state_next inside {ST_RX, ST_RSSI};
         tx_power_on     <= state_next == ST_TX;
         rssi_active     <= state_next == ST_RSSI;
         temp_active     <= temp_active_reg;
         cal_step_active <= (cal_idx_next == CAL_END) ? 5'h00
                            : 5'(5'h01 << cal_idx_next);
         state_code      <= state_next;
      end
   end

   // the baseband clock is half the system clock while the crystal runs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         baseband_clock_out <= 1'b0;
      end else if (state_next != ST_SLEEP && mode_reg[MODE_EXBR_BIT]) begin
         baseband_clock_out <= !baseband_clock_out;
      end else begin
         baseband_clock_out <= 1'b0;
      end
   end

   // read data stand only in the cycle after the read strobe
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (!reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         case (reg_addr)
            REG_MODE:   reg_rdata <= {6'h00, mode_reg};
            REG_CAL1:   reg_rdata <= {7'h00, cal_sel_reg, 1'b0, rssi_man_reg,
                                      1'b0, temp_go_reg};
            REG_CAL2:   reg_rdata <= {13'h0000, rssi_go_reg, cal_go_reg, 1'b0};
            REG_STATUS: reg_rdata <= {4'h0, rx_sync_cnt_reg == RX_SYNC_BITS,
                                      cal_idx_reg, temp_active_reg, state_reg};
            default:    reg_rdata <= 16'h0000;
         endcase
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_wake;
      state_reg == ST_SLEEP && ms0_rise;
   endsequence

   sequence s_cal_end;
      cal_finish && !wr_cal2 && ms0;
   endsequence

   a_sleep_on_low: assert property (!ms0 |=> state_reg == ST_SLEEP)
      else $error("standby pin low did not give sleep");
   a_sleep_clock_off: assert property (state_reg == ST_SLEEP |->
      !baseband_clock_out && !xtal_on && !analog_power_on)
      else $error("clock or power active in sleep");
   a_wake_standby: assert property (s_wake |=>
      state_reg == ST_STANDBY_STATE && xtal_on && !analog_power_on)
      else $error("sleep did not wake to standby");
   a_pll_entry_guard: assert property (
      state_reg == ST_STANDBY_STATE && state_next == ST_PLL |->
      mode_reg[MODE_SYN_BIT] && !ms1 && !cal_go_reg)
      else $error("synth warm entered without its conditions");
   a_tx_select: assert property (state_reg == ST_PLL && ms1_rise && ms0 &&
      mode_reg[MODE_SYN_BIT] && mode_reg[MODE_TRC_BIT] |=>
      state_reg == ST_TX && tx_power_on)
      else $error("tx select not honoured");
   a_no_trx_jump: assert property (state_reg inside {ST_RX, ST_TX} |=>
      !(state_reg inside {ST_RX, ST_TX}) || state_reg == $past(state_reg))
      else $error("direct rx tx swap");
   a_power_split: assert property (state_reg == ST_TX |->
      tx_power_on && !rx_power_on && synth_power_on)
      else $error("tx power split wrong");
   a_cal_normal_end: assert property (s_cal_end |=>
      state_reg == ST_STANDBY_STATE && !cal_go_reg)
      else $error("calibration end did not clear go");
   a_cal_abort: assert property (state_reg == ST_CAL && !cal_go_reg && ms0
      |=> state_reg == ST_STANDBY_STATE && cal_step_active == 5'h00)
      else $error("calibration abort failed");
   a_temp_blocks_cal: assert property (state_reg == ST_STANDBY_STATE &&
      temp_active_reg |=> state_reg != ST_CAL)
      else $error("calibration entered during temperature");
   a_temp_done_clear: assert property (temp_finish && !wr_cal1 && !reg_reset
      |=> !temp_active_reg && !temp_go_reg)
      else $error("temperature end did not clear go");

endmodule : tsc_controller
`default_nettype wire

//--- verif/tsc_host_model.sv
// far-side model: answers calibration, temperature and rssi work
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model import tsc_pkg::*; (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // activity seen from the controller
   input  wire logic [4:0] cal_step_active,
   input  wire logic       temp_active,
   input  wire logic       rssi_active,
   // behaviour select: stall never answers, slow answers late
   input  wire logic       stall,
   input  wire logic       slow,
   // completion pulses
   output logic            cal_step_done,
   output logic            temp_done,
   output logic            rssi_done
);
   logic [4:0] c_cnt;
   logic [4:0] t_cnt;
   logic [4:0] r_cnt;
   logic [4:0] lim;
   assign lim = slow ? 5'h0c : 5'h03;
   // one pulse per step; counter restarts so a lagging flag is not re-answered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {c_cnt, t_cnt, r_cnt} <= '0;
         {cal_step_done, temp_done, rssi_done} <= '0;
      end else begin
         {cal_step_done, temp_done, rssi_done} <= '0;
         if (|cal_step_active && !stall) begin
            cal_step_done <= (c_cnt == lim);
            c_cnt <= (c_cnt == lim) ? 5'h00 : c_cnt + 5'h01;
         end else c_cnt <= '0;
         if (temp_active && !stall) begin
            temp_done <= (t_cnt == lim);
            t_cnt <= (t_cnt == lim) ? 5'h00 : t_cnt + 5'h01;
         end else t_cnt <= '0;
         if (rssi_active && !stall) begin
            rssi_done <= (r_cnt == lim);
            r_cnt <= (r_cnt == lim) ? 5'h00 : r_cnt + 5'h01;
         end else r_cnt <= '0;
      end
   end
endmodule : tsc_host_model
`default_nettype wire

//--- verif/tsc_controller_tb.sv
// self-checking testbench of the transceiver state controller
`timescale 1ns/1ps
`default_nettype none
module tsc_controller_tb;
   import tsc_pkg::*;
   logic clk_sys = 0, rst = 1, sb = 0, ra = 0, hw_n = 1, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata, d;
   logic cdone, tdone, rdone, bb, xt, an, sy, rxp, txp, rs, ta, stall = 0;
   logic slow = 0, zero = 0;
   logic [4:0] cs;
   logic [6:0] st;
   int num_errors = 0, cmp_count = 0;
   always #2.5 clk_sys = ~clk_sys;
   // short bit period keeps the 12-bit calibration ending brief
   tsc_controller #(.CYCLES_PER_US(6)) dut (.clk_sys(clk_sys), .rst(rst),
      .standby_select_pin(sb), .radio_active_pin(ra), .hw_reset_pin_n(hw_n),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .rx_frame_pulse(zero), .fifo_packet_flag(zero),
      .cal_step_done(cdone), .temp_done(tdone), .rssi_done(rdone),
      .baseband_clock_out(bb), .xtal_on(xt), .analog_power_on(an),
      .synth_power_on(sy), .rx_power_on(rxp), .tx_power_on(txp),
      .rssi_active(rs), .temp_active(ta), .cal_step_active(cs),
      .state_code(st));
   tsc_host_model host (.clk_sys(clk_sys), .rst(rst), .cal_step_active(cs),
      .temp_active(ta), .rssi_active(rs), .stall(stall), .slow(slow),
      .cal_step_done(cdone), .temp_done(tdone), .rssi_done(rdone));
   task automatic complete_run();
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [15:0] probe(input int sel);
      case (sel)
         0: probe = {9'h000, st};
         1: probe = {11'h000, cs};
         default: probe = {15'h0000, ta};
      endcase
   endfunction : probe
   task automatic waitv(input int sel, input logic [15:0] e, input int n);
      int i;
      for (i = 0; i < n && probe(sel) !== e; i++) @(posedge clk_sys) #1;
      chk("wait", e, probe(sel));
      if (probe(sel) !== e) complete_run();
   endtask : waitv
   task automatic wreg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      wr <= 1; addr <= a; wdata <= v;
      @(posedge clk_sys);
      wr <= 0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      rd <= 1; addr <= a;
      @(posedge clk_sys);
      rd <= 0;
      #1 chk("rdata", e, rdata);
   endtask : rreg
   task automatic t_power();
      chk("sleep", 16'h0001, {9'h0, st});
      chk("xtal bb", 16'h0000, {14'h0, xt, bb});
      @(posedge clk_sys) sb <= 1;
      waitv(0, 16'h0002, 8);
      chk("xtal analog", 16'h0002, {14'h0, xt, an});
      d = {15'h0, bb};
      @(posedge clk_sys) #1;
      chk("bb toggle", {15'h0, ~d[0]}, {15'h0, bb});
   endtask : t_power
   task automatic t_radio();
      wreg(REG_MODE, 16'h0187);
      waitv(0, 16'h0004, 8);
      chk("synth", 16'h0001, {15'h0, sy});
      @(posedge clk_sys) ra <= 1;
      waitv(0, 16'h0008, 8);
      chk("rx tx", 16'h0002, {14'h0, rxp, txp});
      @(posedge clk_sys) ra <= 0;
      waitv(0, 16'h0004, 8);
      wreg(REG_MODE, 16'h018f);
      @(posedge clk_sys) ra <= 1;
      waitv(0, 16'h0010, 8);
      chk("tx rx synth", 16'h0003, {13'h0, rxp, txp, sy});
      @(posedge clk_sys) sb <= 0;
      waitv(0, 16'h0001, 8);
      chk("xtal off", 16'h0000, {15'h0, xt});
      @(posedge clk_sys) ra <= 0;
   endtask : t_radio
   task automatic t_rssi();
      slow <= 1;
      @(posedge clk_sys) sb <= 1;
      waitv(0, 16'h0002, 8);
      wreg(REG_MODE, 16'h0187);
      waitv(0, 16'h0004, 8);
      wreg(REG_CAL1, 16'h0004);
      wreg(REG_CAL2, 16'h0004);
      @(posedge clk_sys) ra <= 1;
      waitv(0, 16'h0020, 10);
      chk("rssi rx", 16'h0003, {14'h0, rs, rxp});
      waitv(0, 16'h0008, 40);
      wreg(REG_CAL1, 16'h0000);
      @(posedge clk_sys) zero <= 1;
      waitv(0, 16'h0020, 8);
      @(posedge clk_sys) zero <= 0;
      waitv(0, 16'h0008, 40);
      @(posedge clk_sys) ra <= 0;
      waitv(0, 16'h0004, 8);
      slow <= 0;
   endtask : t_rssi
   task automatic t_cal();
      wreg(REG_MODE, 16'h0383);
      waitv(0, 16'h0002, 8);
      // settling waits are scaled down; the logic does not time them
      repeat (4) @(posedge clk_sys);
      wreg(REG_CAL1, 16'h0070);
      wreg(REG_CAL2, 16'h0002);
      waitv(0, 16'h0040, 8);
      waitv(1, 16'h0001, 8);
      waitv(1, 16'h0004, 20);
      waitv(1, 16'h0000, 20);
      chk("ending", 16'h0040, {9'h0, st});
      waitv(0, 16'h0002, 200);
      rreg(REG_CAL2, 16'h0000);
      stall <= 1;
      wreg(REG_CAL2, 16'h0002);
      waitv(0, 16'h0040, 8);
      wreg(REG_CAL2, 16'h0000);
      waitv(0, 16'h0002, 8);
      chk("steps", 16'h0000, {11'h0, cs});
      stall <= 0;
   endtask : t_cal
   task automatic t_temp_regs();
      wreg(REG_CAL1, 16'h0001);
      waitv(2, 16'h0001, 8);
      waitv(2, 16'h0000, 30);
      rreg(REG_CAL1, 16'h0000);
      wreg(REG_MODE, 16'h0000);
      rreg(REG_MODE, 16'h0083);
      wreg(REG_MODE, 16'h0383);
      @(posedge clk_sys) hw_n <= 0;
      repeat (4) @(posedge clk_sys);
      hw_n <= 1;
      repeat (3) @(posedge clk_sys);
      rreg(REG_MODE, 16'h0083);
      rreg(REG_STATUS, 16'h0502);
      rreg(8'h10, 16'h0000);
   endtask : t_temp_regs
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      #1;
      t_power();
      t_radio();
      t_rssi();
      t_cal();
      t_temp_regs();
      complete_run();
   end
endmodule : tsc_controller_tb
`default_nettype wire
